// *** hw/sar_adc_control.sv ***
`include "sar_adc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
    import sar_adc_pkg::*;
#(
    parameter int LARGE_VARIANT = 1
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RC_OSC,
    input  wire logic        SLEEP_IN,
    input  wire logic        COMP_IN,
    input  wire logic [7:0]  PORT_PIN_IN,
    output logic      [7:0]  PORT_READ,
    output logic      [7:0]  DAC_CODE,
    output logic             SAMPLE_EN,
    output logic      [2:0]  CHANNEL_ROUTE,
    output logic             CHANNEL_VALID,
    output logic             VREF_EXT_SEL,
    output logic      [7:0]  ANALOG_PIN_MASK,
    output logic             CONV_POWER,
    output logic             CONV_COMPLETE_FLAG
);

    // ****************************************************************
    // synchronisers for asynchronous inputs
    // ****************************************************************
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic slp_s1_q, slp_s2_q;
    logic cmp_s1_q, cmp_s2_q;
    logic [7:0] pin_s1_q, pin_s2_q;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rc_s1_q  <= 1'b0;
            rc_s2_q  <= 1'b0;
            rc_s3_q  <= 1'b0;
            slp_s1_q <= 1'b0;
            slp_s2_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            rc_s1_q  <= RC_OSC;
            rc_s2_q  <= rc_s1_q;
            rc_s3_q  <= rc_s2_q;
            slp_s1_q <= SLEEP_IN;
            slp_s2_q <= slp_s1_q;
            cmp_s1_q <= COMP_IN;
            cmp_s2_q <= cmp_s1_q;
            pin_s1_q <= PORT_PIN_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************************************
    // registers and decode
    // ****************************************************************
    conv_clk_t   clk_sel_q;
    logic [2:0]  chan_q;
    logic        go_q;
    logic        pwr_q;
    logic [2:0]  cfg_q;
    logic [7:0]  result_q;
    logic        flag_q;
    conv_state_t state_q;
    logic [4:0]  half_cnt_q;
    logic [4:0]  div_cnt_q;
    logic [7:0]  sar_q;
    logic [7:0]  trial_q;
    logic [31:0] rdata_q;

    logic [9:0]  idx;
    logic        hit_ctrl, hit_cfg, hit_res, hit_stat, hit_any;
    logic        wr_en;
    logic        half_tick;
    logic        conv_end;
    logic        abort;
    logic [4:0]  half_div;
    logic [7:0]  cfg_mask;
    logic        cfg_ext;
    logic [7:0]  ctrl_rd;

    assign idx      = PADDR[11:2];
    assign hit_ctrl = (idx == `CONV_CTRL_IDX);
    assign hit_cfg  = (idx == `PIN_CFG_IDX);
    assign hit_res  = (idx == `CONV_RESULT_IDX);
    assign hit_stat = (idx == `CONV_STATUS_IDX);
    assign hit_any  = hit_ctrl | hit_cfg | hit_res | hit_stat;
    assign wr_en    = PSEL & PENABLE & PWRITE & hit_any;

    // zero-wait slave; unmapped addresses answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit_any;
    assign PRDATA  = rdata_q;

    // ****************************************************************
    // pin function decode
    // ****************************************************************
    always_comb begin
        cfg_ext  = 1'b0;
        cfg_mask = `MASK_NONE;
        unique case (cfg_q)
            3'h0: cfg_mask = `MASK_ALL;
            3'h1: begin
                cfg_mask = `MASK_ALL_REF;
                cfg_ext  = 1'b1;
            end
            3'h2: cfg_mask = `MASK_PORTA;
            3'h3: begin
                cfg_mask = `MASK_PORTA_REF;
                cfg_ext  = 1'b1;
            end
            3'h4: cfg_mask = `MASK_THREE;
            3'h5: begin
                cfg_mask = `MASK_TWO_REF;
                cfg_ext  = 1'b1;
            end
            3'h6, 3'h7: cfg_mask = `MASK_NONE;
        endcase
        if (LARGE_VARIANT == 0) begin
            cfg_mask = cfg_mask & `MASK_SMALL;
        end
    end

    // ****************************************************************
    // bit period timebase
    // ****************************************************************
    always_comb begin
        unique case (clk_sel_q)
            CLK_DIV2:  half_div = `HALF_DIV2;
            CLK_DIV8:  half_div = `HALF_DIV8;
            CLK_DIV32: half_div = `HALF_DIV32;
            CLK_RC:    half_div = `HALF_DIV2;
        endcase
    end

    // the system oscillator halts in sleep, so only rc ticks survive it
    always_ff @(posedge CLOCK) begin
        if (RST || div_cnt_q == half_div - 5'h01) begin
            div_cnt_q <= 5'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 5'h01;
        end
    end

    always_comb begin
        if (clk_sel_q == CLK_RC) begin
            half_tick = rc_s2_q ^ rc_s3_q;
        end else begin
            half_tick = (div_cnt_q == half_div - 5'h01)
                        & ~slp_s2_q;
        end
    end

    assign conv_end = (state_q == ST_CONV) & half_tick
                      & (half_cnt_q == `CONV_HALF_TADS - 5'h01);
    assign abort    = (state_q == ST_CONV) & wr_en & hit_ctrl
                      & ~PWDATA[`CTRL_GO_BIT];

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            clk_sel_q <= CLK_DIV2;
            chan_q    <= 3'h0;
            pwr_q     <= 1'b0;
            cfg_q     <= `CFG_RESET;
        end else if (wr_en && hit_ctrl) begin
            clk_sel_q <= conv_clk_t'(PWDATA[`CTRL_CLK_HI:`CTRL_CLK_LO]);
            chan_q    <= PWDATA[`CTRL_CH_HI:`CTRL_CH_LO];
            pwr_q     <= PWDATA[`CTRL_PWR_BIT];
        end else if (wr_en && hit_cfg) begin
            cfg_q     <= PWDATA[`CFG_HI:0];
        end
    end

    // hardware clear on completion beats a software write that cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            go_q <= 1'b0;
        end else if (conv_end || !pwr_q) begin
            go_q <= 1'b0;
        end else if (wr_en && hit_ctrl) begin
            go_q <= PWDATA[`CTRL_GO_BIT];
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q    <= ST_OFF;
            half_cnt_q <= 5'h00;
        end else if (!pwr_q) begin
            state_q    <= ST_OFF;
            half_cnt_q <= 5'h00;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    state_q    <= ST_ACQ;
                    half_cnt_q <= 5'h00;
                end
                ST_ACQ: begin
                    // a start during the hold-off waits here for its end
                    if (go_q) begin
                        state_q    <= ST_CONV;
                        half_cnt_q <= 5'h00;
                    end
                end
                ST_CONV: begin
                    if (conv_end || abort) begin
                        state_q    <= ST_HOLD;
                        half_cnt_q <= 5'h00;
                    end else if (half_tick) begin
                        half_cnt_q <= half_cnt_q + 5'h01;
                    end
                end
                ST_HOLD: begin
                    if (half_tick) begin
                        if (half_cnt_q == `HOLD_HALF_TADS - 5'h01) begin
                            state_q    <= ST_ACQ;
                            half_cnt_q <= 5'h00;
                        end else begin
                            half_cnt_q <= half_cnt_q + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // successive approximation
    // ****************************************************************
    // decisions fall on even half periods 2..16; the comparator path
    // is synchronised, so tad shorter than four clocks loses accuracy
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sar_q   <= 8'h00;
            trial_q <= 8'h00;
        end else if (state_q != ST_CONV) begin
            sar_q   <= 8'h80;
            trial_q <= 8'h80;
        end else if (half_tick && !half_cnt_q[0] &&
                     half_cnt_q >= 5'h02 && half_cnt_q <= 5'h10) begin
            sar_q   <= (cmp_s2_q ? sar_q : (sar_q & ~trial_q))
                       | (trial_q >> 1);
            trial_q <= trial_q >> 1;
        end
    end

    // ****************************************************************
    // result and completion flag
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            result_q <= `RESULT_RESET;
        end else if (conv_end) begin
            result_q <= sar_q;
        end else if (wr_en && hit_res) begin
            result_q <= PWDATA[7:0];
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else if (conv_end) begin
            flag_q <= 1'b1;
        end else if (wr_en && hit_stat && !PWDATA[`STAT_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // read data, captured in the setup cycle
    // ****************************************************************
    always_comb begin
        ctrl_rd = {clk_sel_q, chan_q, go_q, 1'b0, pwr_q};
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rdata_q <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            if (hit_ctrl) begin
                rdata_q <= {24'h000000, ctrl_rd};
            end else if (hit_cfg) begin
                rdata_q <= {29'h00000000, cfg_q};
            end else if (hit_res) begin
                rdata_q <= {24'h000000, result_q};
            end else if (hit_stat) begin
                rdata_q <= {28'h0000000, state_q,
                            (state_q == ST_CONV), flag_q};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // analog front end and port outputs
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DAC_CODE        <= 8'h00;
            SAMPLE_EN       <= 1'b0;
            CHANNEL_ROUTE   <= 3'h0;
            CHANNEL_VALID   <= 1'b0;
            VREF_EXT_SEL    <= 1'b0;
            ANALOG_PIN_MASK <= `MASK_ALL;
            CONV_POWER      <= 1'b0;
            PORT_READ       <= 8'h00;
        end else begin
            DAC_CODE        <= sar_q;
            // switch open in conversion and hold-off holds the sample
            SAMPLE_EN       <= (state_q == ST_ACQ);
            CHANNEL_ROUTE   <= chan_q;
            CHANNEL_VALID   <= (LARGE_VARIANT != 0) ||
                               (chan_q <= 3'h4);
            VREF_EXT_SEL    <= cfg_ext;
            ANALOG_PIN_MASK <= cfg_mask;
            CONV_POWER      <= pwr_q;
            PORT_READ       <= pin_s2_q & ~cfg_mask;
        end
    end

    assign CONV_COMPLETE_FLAG = flag_q;

endmodule : sar_adc_control
`default_nettype wire

// *** hw/sar_adc_map.svh ***
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
// Notes on behaviour
// - selected input becomes an unsigned 8-bit code
// - code built by successive approximation on the held sample
// - software picks supply or channel 3 pin as positive reference
// - conversions go on in sleep only on the internal rc clock
// - clock select 00, 01, 10 give oscillator over 2, 8, 32
// - clock select 11 takes the internal rc oscillator
// - channel select bits 5-3 route channel n to the converter
// - small variant has five channels, large variant eight
// - on completion load result, clear start bit, set complete flag
// - clearing start bit aborts, result kept, 2 periods then acquire
// - one conversion lasts nine and a half bit periods
// - control bit 1 and config bits 7-3 read as zero
// - pin codes 000 to 011 pick analog pins and reference
// - codes 100, 101 use lines 0,1(,3); 11x all digital
// - analog-configured pins read as zero on the port
// - two bit periods pass after a conversion before acquiring

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define CONV_CTRL_IDX    10'h01F
`define PIN_CFG_IDX      10'h09F
`define CONV_RESULT_IDX  10'h01E
`define CONV_STATUS_IDX  10'h020

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_CLK_HI      7
`define CTRL_CLK_LO      6
`define CTRL_CH_HI       5
`define CTRL_CH_LO       3
`define CTRL_GO_BIT      2
`define CTRL_PWR_BIT     0
`define CFG_HI           2
`define STAT_FLAG_BIT    0
`define STAT_BUSY_BIT    1
`define CTRL_RESET       8'h00
`define CFG_RESET        3'h0
`define RESULT_RESET     8'h00

// ****************************************************************
// timing in half bit periods and oscillator cycles
// ****************************************************************
`define CONV_HALF_TADS   5'h13
`define HOLD_HALF_TADS   5'h04
`define HALF_DIV2        5'h01
`define HALF_DIV8        5'h04
`define HALF_DIV32       5'h10

// ****************************************************************
// analog pin masks, bit n is channel n
// ****************************************************************
`define MASK_ALL         8'hFF
`define MASK_ALL_REF     8'hF7
`define MASK_PORTA       8'h1F
`define MASK_PORTA_REF   8'h17
`define MASK_THREE       8'h0B
`define MASK_TWO_REF     8'h03
`define MASK_NONE        8'h00
`define MASK_SMALL       8'h1F
`endif

// *** hw/sar_adc_pkg.sv ***
package sar_adc_pkg;
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_ACQ  = 2'b01,
        ST_CONV = 2'b10,
        ST_HOLD = 2'b11
    } conv_state_t;

    typedef enum logic [1:0] {
        CLK_DIV2  = 2'b00,
        CLK_DIV8  = 2'b01,
        CLK_DIV32 = 2'b10,
        CLK_RC    = 2'b11
    } conv_clk_t;
endpackage : sar_adc_pkg

// *** testbench/analog_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// analog sources with sample-and-hold and comparator
// ****************************************************************
module analog_source_model #(
    parameter logic [63:0] LEVELS = 64'h0
) (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic       SAMPLE_EN,
    input  wire logic [2:0] CHANNEL_ROUTE,
    input  wire logic [7:0] DAC_CODE,
    output logic            COMP_IN
);
    logic [7:0] held_q;
    // follows the routed pin only while the switch is closed
    always_ff @(posedge CLOCK) begin
        if (RST)
            held_q <= 8'h00;
        else if (SAMPLE_EN)
            held_q <= LEVELS[{CHANNEL_ROUTE, 3'b000} +: 8];
    end
    // ideal comparator: no offset, so codes land exactly
    assign COMP_IN = (held_q >= DAC_CODE);
endmodule : analog_source_model
`default_nettype wire

// *** testbench/sar_adc_control_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_control_monitor
    import sar_adc_pkg::*;
#(
    parameter int LARGE_VARIANT = 1
) (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [7:0]  PORT_READ,
    input wire logic        SAMPLE_EN,
    input wire logic [2:0]  CHANNEL_ROUTE,
    input wire logic        CHANNEL_VALID,
    input wire logic        VREF_EXT_SEL,
    input wire logic [7:0]  ANALOG_PIN_MASK,
    input wire logic        CONV_POWER,
    input wire logic        CONV_COMPLETE_FLAG
);
    // ****************************************************************
    // helper logic
    // ****************************************************************
    logic       acc, wr_ctrl, wr_cfg, clr_flag;
    logic [7:0] cw_q;
    logic [2:0] cfg_q;
    logic [7:0] mask_exp;
    assign acc      = PSEL && PENABLE && PWRITE;
    assign wr_ctrl  = acc && (PADDR[11:2] == `CONV_CTRL_IDX);
    assign wr_cfg   = acc && (PADDR[11:2] == `PIN_CFG_IDX);
    assign clr_flag = acc && (PADDR[11:2] == `CONV_STATUS_IDX) && !PWDATA[0];
    always_ff @(posedge CLOCK) begin
        if (RST)
            cw_q <= 8'h00;
        else if (wr_ctrl)
            cw_q <= PWDATA[7:0];
    end
    always_ff @(posedge CLOCK) begin
        if (RST)
            cfg_q <= 3'h0;
        else if (wr_cfg)
            cfg_q <= PWDATA[2:0];
    end
    always_comb begin
        case (cfg_q)
            3'h0: mask_exp = 8'hFF;
            3'h1: mask_exp = 8'hF7;
            3'h2: mask_exp = 8'h1F;
            3'h3: mask_exp = 8'h17;
            3'h4: mask_exp = 8'h0B;
            3'h5: mask_exp = 8'h03;
            default: mask_exp = 8'h00;
        endcase
        if (LARGE_VARIANT == 0)
            mask_exp = mask_exp & 8'h1F;
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    AST_POWER_COPY: assert property (
        wr_ctrl ##1 !wr_ctrl |=> CONV_POWER == cw_q[0]) else $error("power bad");
    AST_ROUTE: assert property (
        wr_ctrl ##1 !wr_ctrl |=> CHANNEL_ROUTE == cw_q[5:3]) else $error("route");
    AST_PIN_MASK: assert property (
        wr_cfg ##1 !wr_cfg |=> ANALOG_PIN_MASK == mask_exp) else $error("mask");
    AST_VREF: assert property (
        wr_cfg ##1 !wr_cfg |=> VREF_EXT_SEL == (cfg_q[0] && cfg_q[2:1] != 2'h3))
        else $error("reference select wrong");
    AST_PORT_ZERO: assert property (
        !$past(RST, 2) && $past(ANALOG_PIN_MASK, 2) == ANALOG_PIN_MASK
        |-> (PORT_READ & ANALOG_PIN_MASK) == 8'h00) else $error("port read");
    AST_VARIANT: assert property (
        !$past(RST, 2) && $past(CHANNEL_ROUTE, 2) == CHANNEL_ROUTE
        |-> CHANNEL_VALID == (LARGE_VARIANT != 0 || CHANNEL_ROUTE < 3'h5))
        else $error("channel valid wrong");
    AST_OFF_NO_SAMPLE: assert property (
        !CONV_POWER && $past(!CONV_POWER) |-> !SAMPLE_EN) else $error("sample");
    AST_FLAG_HOLDS: assert property (
        CONV_COMPLETE_FLAG && !clr_flag |=> CONV_COMPLETE_FLAG) else $error("flag");
    AST_HOLD_OFF: assert property (
        $rose(CONV_COMPLETE_FLAG) |-> !SAMPLE_EN [*3]) else $error("hold-off");
    // ****************************************************************
    // covers
    // ****************************************************************
    COV_DONE: cover property ($rose(CONV_COMPLETE_FLAG));
    COV_SAMPLE: cover property ($fell(SAMPLE_EN));
    COV_CFG: cover property (wr_cfg && PWDATA[2:1] == 2'h3);
endmodule : sar_adc_control_monitor
bind sar_adc_control sar_adc_control_monitor #(
    .LARGE_VARIANT(LARGE_VARIANT)) i_sar_adc_control_monitor (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PORT_READ(PORT_READ),
    .SAMPLE_EN(SAMPLE_EN), .CHANNEL_ROUTE(CHANNEL_ROUTE),
    .CHANNEL_VALID(CHANNEL_VALID), .VREF_EXT_SEL(VREF_EXT_SEL),
    .ANALOG_PIN_MASK(ANALOG_PIN_MASK), .CONV_POWER(CONV_POWER),
    .CONV_COMPLETE_FLAG(CONV_COMPLETE_FLAG));
`default_nettype wire

// *** testbench/sar_adc_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_control_tb_top;
    import sar_adc_pkg::*;
    // fosc/2 decides faster than the synchronised comparator settles,
    // so only rail levels convert exactly on the divide-by-2 channels
    localparam logic [63:0] LEVELS = 64'hE3C4_9A7F_3500_B2FF;
    localparam logic [11:0] A_CTRL = {`CONV_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_CFG  = {`PIN_CFG_IDX, 2'b00};
    localparam logic [11:0] A_RES  = {`CONV_RESULT_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {`CONV_STATUS_IDX, 2'b00};
    localparam logic [7:0]  MASKS [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17,
                                          8'h0B, 8'h03, 8'h00, 8'h00};
    logic        CLOCK = 1'b0;
    logic        RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        RC_OSC = 1'b0;
    logic        SLEEP_IN, COMP_IN, SAMPLE_EN, CHANNEL_VALID;
    logic        VREF_EXT_SEL, CONV_POWER, CONV_COMPLETE_FLAG, rc_run, err_v;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd_v;
    logic [7:0]  PORT_PIN_IN, PORT_READ, DAC_CODE, ANALOG_PIN_MASK;
    logic [2:0]  CHANNEL_ROUTE;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    always #12.5 CLOCK = ~CLOCK;
    // rc oscillator stands still unless a test selects it
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (rc_run && cyc % 7 == 0)
            RC_OSC <= ~RC_OSC;
    end
    sar_adc_control i_sar_adc_control (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RC_OSC(RC_OSC),
        .SLEEP_IN(SLEEP_IN), .COMP_IN(COMP_IN), .PORT_PIN_IN(PORT_PIN_IN),
        .PORT_READ(PORT_READ), .DAC_CODE(DAC_CODE), .SAMPLE_EN(SAMPLE_EN),
        .CHANNEL_ROUTE(CHANNEL_ROUTE), .CHANNEL_VALID(CHANNEL_VALID),
        .VREF_EXT_SEL(VREF_EXT_SEL), .ANALOG_PIN_MASK(ANALOG_PIN_MASK),
        .CONV_POWER(CONV_POWER), .CONV_COMPLETE_FLAG(CONV_COMPLETE_FLAG));
    analog_source_model #(.LEVELS(LEVELS)) i_analog_source_model (
        .CLOCK(CLOCK), .RST(RST), .SAMPLE_EN(SAMPLE_EN),
        .CHANNEL_ROUTE(CHANNEL_ROUTE), .DAC_CODE(DAC_CODE), .COMP_IN(COMP_IN));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    // called just after an edge; one idle edge after release
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd_v = PRDATA;
        err_v = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask : apb
    task automatic wait_sample;
        for (int i = 0; i < 300 && SAMPLE_EN !== 1'b1; i++) @(posedge CLOCK);
        repeat (40) @(posedge CLOCK); // acquisition time before start
    endtask : wait_sample
    task final_report;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        apb(0, A_CTRL, 0);
        check(rd_v, 32'h0);
        apb(1, A_CTRL, 32'hFFFF_FFFA);
        apb(0, A_CTRL, 0);
        check(rd_v, 32'hF8);
        apb(1, A_CFG, 32'hFF);
        apb(0, A_CFG, 0);
        check(rd_v, 32'h07);
        apb(0, 12'h004, 0);
        check(err_v, 1'b1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_pins;
        for (int c = 0; c < 8; c++) begin
            apb(1, A_CFG, c);
            repeat (4) @(posedge CLOCK);
            check(ANALOG_PIN_MASK, MASKS[c]);
            check(VREF_EXT_SEL, c[0] && c[2:1] != 2'h3);
            check(PORT_READ, PORT_PIN_IN & ~MASKS[c]);
        end
        apb(1, A_CFG, 0);
        $display("test pins done");
    endtask : t_pins
    task automatic t_conv(input logic [1:0] cs, input logic [2:0] ch,
                          input int half, input logic sl);
        int n;
        rc_run <= (cs == 2'b11);
        apb(1, A_CTRL, {cs, ch, 3'b001}); // configure and power in one write
        wait_sample();
        check(CHANNEL_ROUTE, ch);
        check(CHANNEL_VALID, 1'b1);
        check(DAC_CODE, 8'h80);
        SLEEP_IN <= sl;
        apb(1, A_CTRL, {cs, ch, 3'b101});
        apb(0, A_CTRL, 0);
        check(rd_v[2], 1'b1);
        if (sl && cs != 2'b11) begin
            repeat (60) @(posedge CLOCK);
            check(CONV_COMPLETE_FLAG, 1'b0);
            SLEEP_IN <= 1'b0;
        end
        for (n = 0; n < 800 && CONV_COMPLETE_FLAG !== 1'b1; n++)
            @(posedge CLOCK);
        n = n + 5;
        if (!sl || cs == 2'b11) begin
            check(n >= 18 * half, 1'b1);
            check(n <= 20 * half + 6, 1'b1);
        end
        SLEEP_IN <= 1'b0;
        apb(0, A_RES, 0);
        check(rd_v, LEVELS[{ch, 3'b000} +: 8]);
        apb(0, A_CTRL, 0);
        check(rd_v, {cs, ch, 3'b001});
        check(CONV_COMPLETE_FLAG, 1'b1);
        apb(1, A_STAT, 0);
        check(CONV_COMPLETE_FLAG, 1'b0);
        $display("test conversion %0d done", cs);
    endtask : t_conv
    task automatic t_abort;
        int n;
        apb(1, A_RES, 32'h5A);
        apb(1, A_CTRL, 32'h51);
        wait_sample();
        apb(1, A_CTRL, 32'h55);
        repeat (30) @(posedge CLOCK);
        apb(1, A_CTRL, 32'h51);
        for (n = 1; n < 200 && SAMPLE_EN !== 1'b1; n++) @(posedge CLOCK);
        check(n >= 12 && n <= 26, 1'b1);
        repeat (120) @(posedge CLOCK);
        check(CONV_COMPLETE_FLAG, 1'b0);
        apb(0, A_RES, 0);
        check(rd_v, 32'h5A);
        apb(1, A_CTRL, 0);
        repeat (3) @(posedge CLOCK);
        check(CONV_POWER, 1'b0);
        apb(0, A_STAT, 0);
        check(rd_v[3:2], 2'h0);
        $display("test abort done");
    endtask : t_abort
    initial begin
        {PSEL, PENABLE, PWRITE, SLEEP_IN, rc_run} = 5'h00;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        PORT_PIN_IN = 8'hB6; // pins stay inputs, bench drives them
        RST = 1'b1;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        t_regs();
        t_pins();
        t_conv(2'b00, 3'd0, 1, 1'b0);
        t_conv(2'b01, 3'd5, 4, 1'b0);
        t_conv(2'b10, 3'd3, 16, 1'b0);
        t_conv(2'b11, 3'd7, 7, 1'b1);
        t_conv(2'b00, 3'd2, 1, 1'b1);
        t_abort();
        final_report();
    end
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
endmodule : sar_adc_control_tb_top
`default_nettype wire
